// ---- bench/dccp_tb_top.sv ----
// Self-checking bench for the dual capture/compare/PWM block
`timescale 1ns/1ps
`default_nettype none
module dccp_tb_top;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pin1, pready, pslverr, o1, oe1, o2, oe2, adc, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] ws;
  int mismatches = 0;
  int total_checks = 0;
  int cnt [4] = '{1, 1, 4, 16};
  // Wait targets: pin high, conversion start, pin low, interrupt
  assign ws = {irq, ~o1, adc, o1};
  always #10 clk = ~clk;
  // Channel two pin input held low: its capture path is the same logic as channel one
  dccp_top DUT (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CH1_PIN(pin1), .I_CH2_PIN(1'b0),
    .O_CH1_PIN(o1), .O_CH1_OE(oe1), .O_CH2_PIN(o2), .O_CH2_OE(oe2), .O_ADC_START(adc),
    .O_IRQ(irq));
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 300) begin
      mismatches++;
      test_done();
    end
  endtask
  // Request held from setup until the edge that sees ready
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 300);
    tmo(n);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdata, exp);
  endtask
  task automatic wt(input int k);
    int n;
    n = 0;
    while (ws[k] !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    tmo(n);
  endtask
  // Six cycles per level covers synchroniser and capture latency
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      pin1 <= 1'b1;
      repeat (6) @(posedge clk);
      pin1 <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  // Skips one period so a duty change has landed, then counts high cycles
  task automatic pwm(input int e1, input int e2);
    int n, h1, h2;
    logic p1, p2;
    n = 0;
    do begin
      p1 = o1;
      p2 = o2;
      @(posedge clk);
      n++;
    end while (!(o1 === 1'b1 && p1 === 1'b0) && n < 300);
    tmo(n);
    chk({p2, o2}, 2'b01);
    repeat (16) @(posedge clk);
    h1 = 0;
    h2 = 0;
    repeat (16) begin
      @(posedge clk);
      h1 += o1;
      h2 += o2;
    end
    chk(h1, e1);
    chk(h2, e2);
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, pin1, paddr, pwdata} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(dccp_pkg::IDX_CH1_MODE, 32'h0);
    rd(dccp_pkg::IDX_CH2_MODE, 32'h0);
    rd(dccp_pkg::IDX_PERIOD, 32'hFF);
    rd(dccp_pkg::IDX_CTRL, 32'h0);
    rd(dccp_pkg::IDX_STATUS, 32'h0);
    rd(dccp_pkg::IDX_MASK, 32'h0);
    rd(8'h30, 32'h0);
    chk(rerr, 1'b1);
    wr(dccp_pkg::IDX_CH1_MODE, 32'hFF);
    rd(dccp_pkg::IDX_CH1_MODE, 32'h3F);
    wr(dccp_pkg::IDX_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(dccp_pkg::IDX_CH1_MODE, 32'h0);
      wr(dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER, 32'h1000 + i);
      wr(dccp_pkg::IDX_STATUS, 32'h7);
      wr(dccp_pkg::IDX_CH1_MODE, 32'h4 + i);
      pulse(cnt[i] - 1);
      rd(dccp_pkg::IDX_STATUS, 32'h0);
      pulse(1);
      rd(dccp_pkg::IDX_STATUS, 32'h1);
      rd(dccp_pkg::IDX_CH1_VAL, 32'h1000 + i);
      chk(irq, 1'b1);
      wr(dccp_pkg::IDX_STATUS, 32'h1);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    wr(dccp_pkg::IDX_MASK, 32'h0);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h5);
    wr(dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER, 32'h2222);
    pulse(1);
    wr(dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER, 32'h3333);
    pulse(1);
    rd(dccp_pkg::IDX_CH1_VAL, 32'h3333);
    chk(irq, 1'b0);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h0);
    wr(dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER, 32'h0);
    wr(dccp_pkg::IDX_CH1_VAL, 32'h20);
    wr(dccp_pkg::IDX_STATUS, 32'h7);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h8);
    wr(dccp_pkg::IDX_CTRL, 32'h1);
    wt(0);
    rd(dccp_pkg::IDX_STATUS, 32'h1);
    wr(dccp_pkg::IDX_STATUS, 32'h1);
    wr(dccp_pkg::IDX_CH1_VAL, 32'h80);
    wr(dccp_pkg::IDX_CH1_MODE, 32'hA);
    wr(dccp_pkg::IDX_MASK, 32'h1);
    wt(3);
    chk(o1, 1'b1);
    wr(dccp_pkg::IDX_STATUS, 32'h1);
    wr(dccp_pkg::IDX_MASK, 32'h0);
    wr(dccp_pkg::IDX_CH1_VAL, 32'hC0);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h9);
    wt(2);
    rd(dccp_pkg::IDX_STATUS, 32'h1);
    wr(dccp_pkg::IDX_CH1_VAL, 32'h100);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h8);
    wt(0);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h0);
    repeat (2) @(posedge clk);
    chk({oe1, o1}, 2'b00);
    wr(dccp_pkg::IDX_CTRL, 32'h0);
    wr(dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER, 32'h0);
    wr(dccp_pkg::IDX_CH2_VAL, 32'h10);
    wr(dccp_pkg::IDX_STATUS, 32'h7);
    wr(dccp_pkg::IDX_CH2_MODE, 32'hB);
    wr(dccp_pkg::IDX_CTRL, 32'h5);
    wt(1);
    chk(o2, 1'b0);
    chk(oe2, 1'b1);
    apb(1'b0, dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER, 32'h0);
    chk({31'h0, rdata < 32'h10}, 32'h1);
    rd(dccp_pkg::IDX_STATUS, 32'h2);
    wr(dccp_pkg::IDX_CTRL, 32'h0);
    wr(dccp_pkg::IDX_CH2_MODE, 32'h0);
    wr(dccp_pkg::IDX_PERIOD, 32'h3);
    wr(dccp_pkg::IDX_CH1_DUTY, 32'h1);
    wr(dccp_pkg::IDX_CH1_MODE, 32'h0C);
    wr(dccp_pkg::IDX_CH2_DUTY, 32'h2);
    wr(dccp_pkg::IDX_CH2_MODE, 32'h2C);
    wr(dccp_pkg::IDX_CTRL, 32'h2);
    pwm(4, 10);
    wr(dccp_pkg::IDX_CH1_DUTY, 32'h2);
    pwm(8, 10);
    test_done();
  end
endmodule // dccp_tb_top
`default_nettype wire

// ---- bench/dccp_top_monitor.sv ----
// Port-level checker for the dual capture/compare/PWM block
`timescale 1ns/1ps
`default_nettype none
module dccp_top_monitor (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // APB
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // Pins and events
  input wire logic I_CH1_PIN,
  input wire logic I_CH2_PIN,
  input wire logic O_CH1_PIN,
  input wire logic O_CH1_OE,
  input wire logic O_CH2_PIN,
  input wire logic O_CH2_OE,
  input wire logic O_ADC_START,
  input wire logic O_IRQ
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  wire wr = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  wire wr1 = wr && I_PADDR == 12'h05C;
  wire wr2 = wr && I_PADDR == 12'h074;
  chk_ready_after_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  chk_error_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  chk_rdata_idle: assert property (!(I_PSEL && I_PENABLE && !I_PWRITE) |-> O_PRDATA == 32'h0)
    else $error("read data outside read access");
  chk_mode_upper_zero: assert property (
    O_PREADY && !I_PWRITE && I_PADDR == 12'h05C |-> O_PRDATA[31:6] == 26'h0)
    else $error("mode upper bits not zero");
  chk_off_one_idle: assert property (
    wr1 && I_PWDATA[3:0] == 4'h0 |-> ##[1:2] (!O_CH1_OE && !O_CH1_PIN))
    else $error("channel one not idle after off");
  chk_off_two_idle: assert property (
    wr2 && I_PWDATA[3:0] == 4'h0 |-> ##[1:2] (!O_CH2_OE && !O_CH2_PIN))
    else $error("channel two not idle after off");
  chk_compare_drives: assert property (wr1 && I_PWDATA[3] |-> ##[1:2] O_CH1_OE)
    else $error("no output enable in compare or pwm");
  chk_capture_input: assert property (wr1 && I_PWDATA[3:2] == 2'h1 |-> ##[1:2] !O_CH1_OE)
    else $error("output enable in capture");
  chk_adc_single: assert property (O_ADC_START |=> !O_ADC_START)
    else $error("conversion start longer than one cycle");
  chk_adc_from_two: assert property (O_ADC_START |-> O_CH2_OE)
    else $error("conversion start outside compare");
  cover property (O_ADC_START);
  cover property (O_PSLVERR);
  cover property ($rose(O_CH1_PIN) && $rose(O_CH2_PIN));
  cover property ($rose(O_IRQ));
endmodule // dccp_top_monitor
bind dccp_top dccp_top_monitor u_mon (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_CH1_PIN(I_CH1_PIN), .I_CH2_PIN(I_CH2_PIN), .O_CH1_PIN(O_CH1_PIN), .O_CH1_OE(O_CH1_OE),
  .O_CH2_PIN(O_CH2_PIN), .O_CH2_OE(O_CH2_OE), .O_ADC_START(O_ADC_START), .O_IRQ(O_IRQ));
`default_nettype wire

// ---- design/dccp_chan.sv ----
// One capture/compare/PWM channel: capture, compare and PWM datapath
`timescale 1ns/1ps
`default_nettype none
module dccp_chan (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Link to the top
  dccp_chan_if.chan ch
);
  logic [15:0] val_q;
  logic [9:0] duty_q;
  logic [3:0] presc_q;
  logic pin_prev_q;
  logic match_q;
  logic pin_q;
  logic oe_q;
  logic evt_q;
  logic trig_q;

  wire is_off = ch.mode == dccp_pkg::M_OFF;
  wire is_cap = ch.mode[3:2] == 2'b01;
  wire is_cmp = ch.mode[3:2] == 2'b10;
  wire is_pwm = ch.mode[3:2] == 2'b11;
  wire rise = ch.pin_in & ~pin_prev_q;
  wire fall = ~ch.pin_in & pin_prev_q;
  wire presc_last = (ch.mode == dccp_pkg::M_CAP_RISE4 && presc_q == dccp_pkg::PRESC_4_LAST) ||
                    (ch.mode == dccp_pkg::M_CAP_RISE16 && presc_q == dccp_pkg::PRESC_16_LAST);
  wire cap_hit = is_cap & ((ch.mode == dccp_pkg::M_CAP_FALL & fall) |
                 (ch.mode == dccp_pkg::M_CAP_RISE & rise) | (rise & presc_last));
  wire match = ch.shared_timebase_counter == val_q;
  wire cmp_hit = is_cmp & match & ~match_q;
  wire [9:0] duty_now = (is_pwm && !ch.period_end) ? duty_q : ch.duty;

  // Prescaler counts rises in all four capture modes, cleared outside capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc_q <= 4'h0;
    end else if (!is_cap || is_off) begin
      presc_q <= 4'h0;
    end else if (rise) begin
      presc_q <= presc_last ? 4'h0 : presc_q + 4'h1;
    end
  end

  // Capture overwrites unread value; a software write loses to a capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      val_q <= 16'h0000;
    end else if (cap_hit) begin
      val_q <= ch.shared_timebase_counter;
    end else if (ch.val_wr) begin
      val_q <= ch.val_wdata;
    end
  end

  // Duty takes effect only at the shared period end, so both channels update together
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      duty_q <= 10'h000;
    end else begin
      duty_q <= duty_now;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev_q <= 1'b0;
      match_q <= 1'b0;
      evt_q <= 1'b0;
      trig_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      pin_prev_q <= ch.pin_in;
      match_q <= is_cmp & match;
      evt_q <= cap_hit | cmp_hit;
      trig_q <= cmp_hit & (ch.mode == dccp_pkg::M_CMP_SPECIAL);
      oe_q <= is_cmp | is_pwm;
    end
  end

  // Output latch: low when off, driven by match in compare, by period timer in PWM
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q <= 1'b0;
    end else if (is_off) begin
      pin_q <= 1'b0;
    end else if (is_pwm) begin
      pin_q <= ch.pwm_cnt < duty_now;
    end else if (cmp_hit && ch.mode == dccp_pkg::M_CMP_SET) begin
      pin_q <= 1'b1;
    end else if (cmp_hit && ch.mode == dccp_pkg::M_CMP_CLR) begin
      pin_q <= 1'b0;
    end
  end

  assign ch.val = val_q;
  assign ch.evt = evt_q;
  assign ch.pin_out = pin_q;
  assign ch.pin_oe = oe_q;
  assign ch.spec_trig = trig_q;
endmodule // dccp_chan
`default_nettype wire

// ---- design/dccp_chan_if.sv ----
// Signals between the top and one capture/compare/PWM channel
`timescale 1ns/1ps
`default_nettype none
interface dccp_chan_if;
  logic [3:0] mode;
  logic [9:0] duty;
  logic val_wr;
  logic [15:0] val_wdata;
  logic [15:0] shared_timebase_counter;
  logic [9:0] pwm_cnt;
  logic period_end;
  logic pin_in;
  logic [15:0] val;
  logic evt;
  logic pin_out;
  logic pin_oe;
  logic spec_trig;
  modport top (output mode, duty, val_wr, val_wdata, shared_timebase_counter, pwm_cnt, period_end, pin_in,
    input val, evt, pin_out, pin_oe, spec_trig);
  modport chan (input mode, duty, val_wr, val_wdata, shared_timebase_counter, pwm_cnt, period_end, pin_in,
    output val, evt, pin_out, pin_oe, spec_trig);
endinterface
`default_nettype wire

// ---- design/dccp_pkg.sv ----
// Shared constants for the dual capture/compare/PWM mode-control block
package dccp_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CH1_MODE = 8'h17;
  localparam logic [7:0] IDX_CH2_MODE = 8'h1D;
  localparam logic [7:0] IDX_CH1_VAL = 8'h20;
  localparam logic [7:0] IDX_CH2_VAL = 8'h21;
  localparam logic [7:0] IDX_CH1_DUTY = 8'h22;
  localparam logic [7:0] IDX_CH2_DUTY = 8'h23;
  localparam logic [7:0] IDX_SHARED_TIMEBASE_COUNTER = 8'h24;
  localparam logic [7:0] IDX_PERIOD = 8'h25;
  localparam logic [7:0] IDX_CTRL = 8'h26;
  localparam logic [7:0] IDX_STATUS = 8'h27;
  localparam logic [7:0] IDX_MASK = 8'h28;
  // Mode control fields
  localparam int MODE_LSB = 0;
  localparam int DUTY_LO_LSB = 4;
  localparam logic [5:0] MODE_CTRL_RESET = 6'h00;
  // Control register bits
  localparam int CTRL_SHARED_TIMEBASE_COUNTER_ON = 0;
  localparam int CTRL_PWM_PERIOD_TIMER_ON = 1;
  localparam int CTRL_ADC_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Status / mask bits
  localparam int ST_CH1_EVT = 0;
  localparam int ST_CH2_EVT = 1;
  localparam int ST_PERIOD = 2;
  localparam int ST_WIDTH = 3;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  // Mode select codes
  localparam logic [3:0] M_OFF = 4'h0;
  localparam logic [3:0] M_CAP_FALL = 4'h4;
  localparam logic [3:0] M_CAP_RISE = 4'h5;
  localparam logic [3:0] M_CAP_RISE4 = 4'h6;
  localparam logic [3:0] M_CAP_RISE16 = 4'h7;
  localparam logic [3:0] M_CMP_SET = 4'h8;
  localparam logic [3:0] M_CMP_CLR = 4'h9;
  localparam logic [3:0] M_CMP_SOFT = 4'hA;
  localparam logic [3:0] M_CMP_SPECIAL = 4'hB;
  localparam logic [3:0] PRESC_4_LAST = 4'h3;
  localparam logic [3:0] PRESC_16_LAST = 4'hF;
endpackage

// ---- design/dccp_top.sv ----
// Dual capture/compare/PWM mode control with APB registers and shared timers
//
// How it works
// - Both PWM channels share one period timer; duty updates at its period end.
// - PWM periods of both channels start together, rising edges aligned.
// - Mode register bits 5:4 are duty bits 1:0, used only in PWM.
// - Duty high byte register supplies duty bits 9:2.
// - Mode 0000 disables the channel and resets its internal state.
// - Code 1011 flags, leaves pin, clears shared timer; channel two starts conversion.
// - Capture copies the shared timer into the value register and flags it.
// - Compare checks value against shared timer, applies pin action, flags.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dccp_top (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Channel pins
  input wire logic I_CH1_PIN,
  input wire logic I_CH2_PIN,
  output logic O_CH1_PIN,
  output logic O_CH1_OE,
  output logic O_CH2_PIN,
  output logic O_CH2_OE,
  // System events
  output logic O_ADC_START,
  output logic O_IRQ
);
  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [5:0] mode_q [2];
  logic [7:0] duty_hi_q [2];
  logic [15:0] shared_timebase_counter_q;
  logic [7:0] pwm_period_timer_q;
  logic [1:0] fine_q;
  logic [7:0] period_q;
  logic [2:0] ctrl_q;
  logic [dccp_pkg::ST_WIDTH-1:0] status_q;
  logic [dccp_pkg::ST_WIDTH-1:0] mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic adc_q;
  logic period_end_q;

  dccp_chan_if ch_if[2] ();

  // Reset release through two flops
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Pins are asynchronous to the core clock
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
    end else begin
      pin_s1_q <= {I_CH2_PIN, I_CH1_PIN};
      pin_s2_q <= pin_s1_q;
    end
  end

  // APB decode; pready is registered so read data can come from a flop
  wire setup = I_PSEL & ~I_PENABLE;
  wire access = I_PSEL & I_PENABLE & pready_q;
  wire wr = access & I_PWRITE;
  wire [7:0] idx = I_PADDR[9:2];
  wire addr_ok = I_PADDR[11:10] == 2'b00 && I_PADDR[1:0] == 2'b00;
  wire hit_m1 = addr_ok && idx == dccp_pkg::IDX_CH1_MODE;
  wire hit_m2 = addr_ok && idx == dccp_pkg::IDX_CH2_MODE;
  wire hit_v1 = addr_ok && idx == dccp_pkg::IDX_CH1_VAL;
  wire hit_v2 = addr_ok && idx == dccp_pkg::IDX_CH2_VAL;
  wire hit_d1 = addr_ok && idx == dccp_pkg::IDX_CH1_DUTY;
  wire hit_d2 = addr_ok && idx == dccp_pkg::IDX_CH2_DUTY;
  wire hit_t1 = addr_ok && idx == dccp_pkg::IDX_SHARED_TIMEBASE_COUNTER;
  wire hit_pr = addr_ok && idx == dccp_pkg::IDX_PERIOD;
  wire hit_ct = addr_ok && idx == dccp_pkg::IDX_CTRL;
  wire hit_st = addr_ok && idx == dccp_pkg::IDX_STATUS;
  wire hit_mk = addr_ok && idx == dccp_pkg::IDX_MASK;
  wire hit_any = hit_m1 | hit_m2 | hit_v1 | hit_v2 | hit_d1 | hit_d2 | hit_t1 | hit_pr |
                 hit_ct | hit_st | hit_mk;
  wire [31:0] rd_mux =
    hit_m1 ? {26'h0, mode_q[0]} : hit_m2 ? {26'h0, mode_q[1]} :
    hit_v1 ? {16'h0, ch_if[0].val} : hit_v2 ? {16'h0, ch_if[1].val} :
    hit_d1 ? {24'h0, duty_hi_q[0]} : hit_d2 ? {24'h0, duty_hi_q[1]} :
    hit_t1 ? {16'h0, shared_timebase_counter_q} : hit_pr ? {24'h0, period_q} :
    hit_ct ? {29'h0, ctrl_q} : hit_st ? {29'h0, status_q} :
    hit_mk ? {29'h0, mask_q} : 32'h0;

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      prdata_q <= (setup & ~I_PWRITE) ? rd_mux : 32'h0;
    end
  end

  // Software registers
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_q[0] <= dccp_pkg::MODE_CTRL_RESET;
      mode_q[1] <= dccp_pkg::MODE_CTRL_RESET;
      duty_hi_q[0] <= 8'h00;
      duty_hi_q[1] <= 8'h00;
      period_q <= dccp_pkg::PERIOD_RESET;
      ctrl_q <= dccp_pkg::CTRL_RESET;
      mask_q <= '0;
    end else begin
      if (wr && hit_m1) mode_q[0] <= I_PWDATA[5:0];
      if (wr && hit_m2) mode_q[1] <= I_PWDATA[5:0];
      if (wr && hit_d1) duty_hi_q[0] <= I_PWDATA[7:0];
      if (wr && hit_d2) duty_hi_q[1] <= I_PWDATA[7:0];
      if (wr && hit_pr) period_q <= I_PWDATA[7:0];
      if (wr && hit_ct) ctrl_q <= I_PWDATA[2:0];
      if (wr && hit_mk) mask_q <= I_PWDATA[dccp_pkg::ST_WIDTH-1:0];
    end
  end

  // Shared time-base; either special trigger clears it, outranking a software load
  wire spec_clr = ch_if[0].spec_trig | ch_if[1].spec_trig;
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      shared_timebase_counter_q <= 16'h0000;
    end else if (spec_clr) begin
      shared_timebase_counter_q <= 16'h0000;
    end else if (wr && hit_t1) begin
      shared_timebase_counter_q <= I_PWDATA[15:0];
    end else if (ctrl_q[dccp_pkg::CTRL_SHARED_TIMEBASE_COUNTER_ON]) begin
      shared_timebase_counter_q <= shared_timebase_counter_q + 16'h0001;
    end
  end

  // One period timer for both channels: 8-bit count plus 2 fine bits
  wire period_last = pwm_period_timer_q == period_q && fine_q == 2'b11;
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pwm_period_timer_q <= 8'h00;
      fine_q <= 2'b00;
      period_end_q <= 1'b0;
    end else if (ctrl_q[dccp_pkg::CTRL_PWM_PERIOD_TIMER_ON]) begin
      fine_q <= fine_q + 2'b01;
      period_end_q <= period_last;
      if (period_last) begin
        pwm_period_timer_q <= 8'h00;
      end else if (fine_q == 2'b11) begin
        pwm_period_timer_q <= pwm_period_timer_q + 8'h01;
      end
    end else begin
      period_end_q <= 1'b0;
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  wire [dccp_pkg::ST_WIDTH-1:0] ev = {period_end_q, ch_if[1].evt, ch_if[0].evt};
  wire [dccp_pkg::ST_WIDTH-1:0] w1c = (wr && hit_st) ? I_PWDATA[dccp_pkg::ST_WIDTH-1:0] : '0;
  wire [dccp_pkg::ST_WIDTH-1:0] status_d = (status_q & ~w1c) | ev;
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      irq_q <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
      adc_q <= ch_if[1].spec_trig & ctrl_q[dccp_pkg::CTRL_ADC_EN];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign ch_if[g].mode = mode_q[g][dccp_pkg::MODE_LSB +: 4];
    assign ch_if[g].duty = {duty_hi_q[g], mode_q[g][dccp_pkg::DUTY_LO_LSB +: 2]};
    assign ch_if[g].val_wr = wr & (g == 0 ? hit_v1 : hit_v2);
    assign ch_if[g].val_wdata = I_PWDATA[15:0];
    assign ch_if[g].shared_timebase_counter = shared_timebase_counter_q;
    assign ch_if[g].pwm_cnt = {pwm_period_timer_q, fine_q};
    assign ch_if[g].period_end = period_end_q;
    assign ch_if[g].pin_in = pin_s2_q[g];
    dccp_chan u_chan (
      .i_clk(I_CORE_CLK),
      .i_rst_n(rst_n),
      .ch(ch_if[g])
    );
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_CH1_PIN = ch_if[0].pin_out;
  assign O_CH1_OE = ch_if[0].pin_oe;
  assign O_CH2_PIN = ch_if[1].pin_out;
  assign O_CH2_OE = ch_if[1].pin_oe;
  assign O_ADC_START = adc_q;
  assign O_IRQ = irq_q;
endmodule // dccp_top
`default_nettype wire
